// ---- include/tff_cfg.svh ----
// timing, layout and code constants of the tape frame formatter
`ifndef TFF_CFG_SVH
`define TFF_CFG_SVH

// bit cell and frame timing
`define TFF_BIT_NS 250
`define TFF_DATA_DELAY_NS 7000
`define TFF_DATA_START (`TFF_DATA_DELAY_NS / `TFF_BIT_NS)
`define TFF_DATA_BITS_SHORT 66000
`define TFF_POS_W 17

// frame header layout in bit cells from the frame boundary
`define TFF_SYNC_BITS 8
`define TFF_MARK_POS 8
`define TFF_NUM_POS 10
`define TFF_PAR_POS 16
`define TFF_PAD_POS 17
`define TFF_LAST_FNUM 6'h3b

// sync words as half-cell levels, first half in the top bit
`define TFF_START_SYNC 16'hf0f0
`define TFF_END_SYNC 16'hff00

// slip marker every 0.512 ms
`define TFF_SLIP_NS 512000
`define TFF_SLIP_BITS (`TFF_SLIP_NS / `TFF_BIT_NS)
`define TFF_SLIP_ONES 7

// audio time code
`define TFF_TC_DIV 11'd1042
`define TFF_TC_HALF 11'd521
`define TFF_TC_SPECIAL 12'hffa
`define TFF_TC_SPARE 4'h0

// reference one-shot pulse width in bit cells
`define TFF_REF_WIDTH 17'h003e8

`endif

// ---- include/tff_pkg.sv ----
// types shared by the tape frame formatter
package tff_pkg;
  typedef enum logic [6:0] {
    TFF_IDLE  = 7'b0000001,
    TFF_SSYNC = 7'b0000010,
    TFF_HEAD  = 7'b0000100,
    TFF_PAD   = 7'b0001000,
    TFF_DATA  = 7'b0010000,
    TFF_ESYNC = 7'b0100000,
    TFF_GAP   = 7'b1000000
  } tff_field_type;
endpackage : tff_pkg

// ---- include/tff_bit_if.sv ----
// bit stream handshake between buffer and formatter
`timescale 1ns/10ps
`default_nettype none
interface tff_bit_if;
  logic valid;
  logic ready;
  logic data;
  modport prod (output valid, output data, input ready);
  modport cons (input valid, input data, output ready);
endinterface : tff_bit_if
`default_nettype wire

// ---- verilog/tff_buf2.sv ----
// two-entry bit buffer with registered input ready
`timescale 1ns/10ps
`default_nettype none
module tff_buf2 (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic in_valid,
  input wire logic in_data,
  output logic in_ready,
  tff_bit_if.prod out
);
  logic [1:0] cnt_q;
  logic [1:0] cnt_d;
  logic d0_q;
  logic d1_q;
  logic ready_q;
  logic push;
  logic pop;

  // handshakes on both sides
  assign push = in_valid && ready_q;
  assign pop = out.ready && (cnt_q != 2'h0);
  assign cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
  assign in_ready = ready_q;
  assign out.valid = (cnt_q != 2'h0);
  assign out.data = d0_q;

  // occupancy and ready
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      cnt_q <= 2'h0;
      ready_q <= 1'b0;
    end else if (ce) begin
      cnt_q <= cnt_d;
      ready_q <= (cnt_d != 2'h2);
    end
  end

  // storage, head in d0
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      d0_q <= 1'b0;
      d1_q <= 1'b0;
    end else if (ce) begin
      if (pop) begin
        d0_q <= (cnt_q == 2'h2) ? d1_q : in_data;
        if (push && cnt_q == 2'h2)
          d1_q <= in_data;
      end else if (push) begin
        if (cnt_q == 2'h0)
          d0_q <= in_data;
        else
          d1_q <= in_data;
      end
    end
  end
endmodule : tff_buf2
`default_nettype wire

// ---- verilog/tff_formatter.sv ----
// tape frame formatter: frames, slip markers, diphase, time code, reference
`timescale 1ns/10ps
`default_nettype none
`include "tff_cfg.svh"
module tff_formatter (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic clk4_pin,
  input wire logic tick60_pin,
  input wire logic sec_pin,
  input wire logic long_frame_pin,
  input wire logic [3:0] unit_pin,
  input wire logic [35:0] tod_digits,
  input wire logic [16:0] ref_delay,
  input wire logic in_valid,
  input wire logic in_data,
  output logic in_ready,
  output logic video_out_q,
  output logic tc_out_q,
  output logic ref60_q,
  output logic [5:0] frame_num_q
);
  import tff_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic [2:0] clk4_s;
  logic [2:0] tick_s;
  logic [1:0] sec_s;
  logic [1:0] long_s;
  logic [3:0] unit_s1;
  logic [3:0] unit_s2;
  logic bit_stb;
  logic tick_rise;

  // two stages per pin, third for edge detection and coder phase
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      clk4_s <= 3'h0;
      tick_s <= 3'h0;
      sec_s <= 2'h0;
      long_s <= 2'h0;
      unit_s1 <= 4'h0;
      unit_s2 <= 4'h0;
    end else if (ce) begin
      clk4_s <= {clk4_s[1:0], clk4_pin};
      tick_s <= {tick_s[1:0], tick60_pin};
      sec_s <= {sec_s[0], sec_pin};
      long_s <= {long_s[0], long_frame_pin};
      unit_s1 <= unit_pin;
      unit_s2 <= unit_s1;
    end
  end

  // cell boundary on rising 4 mhz edge, frame boundary on tick edge
  assign bit_stb = clk4_s[1] && !clk4_s[2];
  assign tick_rise = tick_s[1] && !tick_s[2];

  ////////////////////////////////////////////////////////////////////////
  // unit strap capture after reset release

  logic [1:0] strap_cnt_q;
  logic [3:0] unit_q;

  // sample once the synchroniser has filled
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      strap_cnt_q <= 2'h0;
      unit_q <= 4'h0;
    end else if (ce && strap_cnt_q != 2'h3) begin
      strap_cnt_q <= strap_cnt_q + 2'h1;
      unit_q <= unit_s2;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // data buffer

  tff_bit_if buf_if ();

  tff_buf2 u_buf (
    .mclk(mclk),
    .reset_n(reset_n),
    .ce(ce),
    .in_valid(in_valid),
    .in_data(in_data),
    .in_ready(in_ready),
    .out(buf_if.prod)
  );

  ////////////////////////////////////////////////////////////////////////
  // frame sequencing

  tff_field_type field_q;
  tff_field_type field_d;
  logic [`TFF_POS_W-1:0] pos_q;
  logic [`TFF_POS_W-1:0] pos_d;
  logic [`TFF_POS_W-1:0] data_end;
  logic [5:0] fnum_d;
  logic [4:0] num_idx;
  logic cell_q;
  logic cell_d;
  logic end_sync_q;
  logic [2:0] sync_idx_q;
  logic slip_one;
  logic slip_zero;
  logic take;

  // long frames end their data field one cell later
  assign data_end = `TFF_POS_W'(`TFF_DATA_START + `TFF_DATA_BITS_SHORT)
    + {{(`TFF_POS_W-1){1'b0}}, long_s[1]};

  // slip marker positions, zero on a multiple of the interval
  assign slip_one = pos_d[10:0] >= 11'(`TFF_SLIP_BITS - `TFF_SLIP_ONES);
  assign slip_zero = pos_d[10:0] == 11'h000;
  assign num_idx = 5'(`TFF_NUM_POS + 5) - pos_d[4:0];

  // next position, field and cell content
  always_comb begin
    pos_d = pos_q;
    fnum_d = frame_num_q;
    field_d = field_q;
    cell_d = cell_q;
    take = 1'b0;
    if (tick_rise) begin
      pos_d = '0;
      if (sec_s[1] || frame_num_q == `TFF_LAST_FNUM)
        fnum_d = 6'h00;
      else
        fnum_d = frame_num_q + 6'h01;
    end else if (bit_stb && field_q != TFF_IDLE && pos_q != '1) begin
      pos_d = pos_q + `TFF_POS_W'(1);
    end
    if (field_q != TFF_IDLE || tick_rise) begin
      if (pos_d < `TFF_POS_W'(`TFF_SYNC_BITS))
        field_d = TFF_SSYNC;
      else if (pos_d < `TFF_POS_W'(`TFF_PAD_POS))
        field_d = TFF_HEAD;
      else if (pos_d < `TFF_POS_W'(`TFF_DATA_START))
        field_d = TFF_PAD;
      else if (pos_d < data_end)
        field_d = TFF_DATA;
      else if (pos_d < data_end + `TFF_POS_W'(`TFF_SYNC_BITS))
        field_d = TFF_ESYNC;
      else
        field_d = TFF_GAP;
    end
    case (field_d)
      TFF_HEAD: begin
        if (pos_d < `TFF_POS_W'(`TFF_NUM_POS))
          cell_d = (pos_d == `TFF_POS_W'(`TFF_MARK_POS));
        else if (pos_d < `TFF_POS_W'(`TFF_PAR_POS))
          cell_d = fnum_d[num_idx[2:0]];
        else
          cell_d = ^fnum_d;
      end
      TFF_DATA: begin
        if (slip_one)
          cell_d = 1'b1;
        else if (slip_zero)
          cell_d = 1'b0;
        else begin
          take = tick_rise || bit_stb;
          cell_d = buf_if.valid && buf_if.data;
        end
      end
      TFF_PAD, TFF_GAP, TFF_IDLE: cell_d = 1'b1;
      default: cell_d = 1'b0;
    endcase
  end

  // data cells other than slip marker cells pop the buffer; an empty buffer records a zero
  assign buf_if.ready = take;

  // position, field and cell registers
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      pos_q <= '0;
      field_q <= TFF_IDLE;
      cell_q <= 1'b1;
      frame_num_q <= 6'h00;
      end_sync_q <= 1'b0;
      sync_idx_q <= 3'h0;
    end else if (ce && (tick_rise || bit_stb)) begin
      pos_q <= pos_d;
      field_q <= field_d;
      cell_q <= cell_d;
      frame_num_q <= fnum_d;
      end_sync_q <= (field_d == TFF_ESYNC);
      sync_idx_q <= (field_d == TFF_ESYNC) ? 3'(pos_d - data_end)
        : pos_d[2:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // diphase line coder

  logic [3:0] half_idx;
  logic [15:0] sync_word;
  logic sync_lvl;

  // sync words are sent as raw half-cell levels; the third clock stage
  // lines half cells up with the cell register, so no runt at boundaries
  assign half_idx = 4'hf - {sync_idx_q, !clk4_s[2]};
  assign sync_word = end_sync_q ? `TFF_END_SYNC : `TFF_START_SYNC;
  assign sync_lvl = sync_word[half_idx];

  // data cells pick in-phase or inverted clock
  always_ff @(posedge mclk) begin
    if (!reset_n)
      video_out_q <= 1'b0;
    else if (ce) begin
      if (field_q == TFF_SSYNC || field_q == TFF_ESYNC)
        video_out_q <= sync_lvl;
      else
        video_out_q <= cell_q ? clk4_s[2] : !clk4_s[2];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // audio time code

  logic [10:0] tc_div_q;
  logic [63:0] tc_sr_q;

  // bit clock divider, restarted on every tick
  always_ff @(posedge mclk) begin
    if (!reset_n)
      tc_div_q <= 11'h000;
    else if (ce) begin
      if (tick_rise)
        tc_div_q <= 11'h000;
      else if (bit_stb)
        tc_div_q <= (tc_div_q == `TFF_TC_DIV - 11'h001) ? 11'h000
          : tc_div_q + 11'h001;
    end
  end

  // digit set loaded each tick, shifted out msb first
  always_ff @(posedge mclk) begin
    if (!reset_n)
      tc_sr_q <= 64'h0;
    else if (ce) begin
      if (tick_rise)
        tc_sr_q <= {tod_digits, 2'b00, fnum_d, `TFF_TC_SPECIAL, unit_q,
          `TFF_TC_SPARE};
      else if (bit_stb && tc_div_q == `TFF_TC_DIV - 11'h001)
        tc_sr_q <= {tc_sr_q[62:0], 1'b0};
    end
  end

  // diphase: second half of each cell is the inverse of the first
  always_ff @(posedge mclk) begin
    if (!reset_n)
      tc_out_q <= 1'b0;
    else if (ce)
      tc_out_q <= (tc_div_q < `TFF_TC_HALF) ? tc_sr_q[63]
        : !tc_sr_q[63];
  end

  ////////////////////////////////////////////////////////////////////////
  // recorder reference one-shot

  logic [16:0] ref_cnt_q;
  logic ref_armed_q;

  // delay then width, counted in bit cells
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      ref_cnt_q <= 17'h00000;
      ref_armed_q <= 1'b0;
      ref60_q <= 1'b0;
    end else if (ce) begin
      if (tick_rise) begin
        ref_cnt_q <= ref_delay;
        ref_armed_q <= 1'b1;
        ref60_q <= 1'b0;
      end else if (bit_stb) begin
        if (ref_cnt_q != 17'h00000)
          ref_cnt_q <= ref_cnt_q - 17'h00001;
        else if (ref_armed_q) begin
          ref_armed_q <= 1'b0;
          ref60_q <= 1'b1;
          ref_cnt_q <= `TFF_REF_WIDTH;
        end else
          ref60_q <= 1'b0;
      end
    end
  end
endmodule : tff_formatter
`default_nettype wire

// ---- verification/tff_formatter_properties.sv ----
// port checker for the tape frame formatter
`timescale 1ns/10ps
`default_nettype none
module tff_formatter_properties (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic clk4_pin,
  input wire logic tick60_pin,
  input wire logic sec_pin,
  input wire logic [16:0] ref_delay,
  input wire logic in_valid,
  input wire logic in_ready,
  input wire logic video_out_q,
  input wire logic ref60_q,
  input wire logic [5:0] frame_num_q
);
  logic [2:0] c4_q;
  logic [2:0] age_q;
  logic [10:0] hi_q;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);
  // resync cell clock, age since its last edge
  always_ff @(posedge mclk) begin
    c4_q <= {c4_q[1:0], clk4_pin};
    if (!reset_n || c4_q[2] != c4_q[1]) age_q <= 3'h0;
    else if (age_q != 3'h7) age_q <= age_q + 3'h1;
  end
  // cells counted under the reference pulse
  always_ff @(posedge mclk) begin
    if (!ref60_q) hi_q <= 11'h000;
    else if (c4_q[1] && !c4_q[2]) hi_q <= hi_q + 11'h001;
  end
  //////////////////////////////////////////////////////////////////
  sequence tick_s;
    $rose(tick60_pin);
  endsequence
  sequence quiet_s;
    !ref60_q [*8];
  endsequence
  chk_fnum_range: assert property (frame_num_q <= 6'h3b)
    else $error("frame number too big");
  chk_fnum_second: assert property (
    tick_s ##0 sec_pin |-> ##[1:6] frame_num_q == 6'h00)
    else $error("no zero on the second");
  chk_fnum_wrap: assert property (
    tick_s ##0 (!sec_pin && frame_num_q == 6'h3b)
    |-> ##[1:6] frame_num_q == 6'h00) else $error("no wrap");
  chk_fnum_step: assert property (
    $changed(frame_num_q) |-> frame_num_q == 6'h00 ||
    frame_num_q == $past(frame_num_q) + 6'h01) else $error("bad step");
  chk_fnum_tick: assert property (
    $changed(frame_num_q) |-> $past(tick60_pin, 3))
    else $error("frame number moved off tick");
  chk_cell_edges: assert property (
    $changed(video_out_q) && !tick60_pin && !$past(tick60_pin, 3)
    |-> age_q <= 3'h3) else $error("video edge off cell grid");
  chk_ref_width: assert property (
    $fell(ref60_q) && !$past(tick60_pin, 3)
    |-> hi_q >= 11'h3e8 && hi_q <= 11'h3ea)
    else $error("reference width wrong");
  chk_ref_restart: assert property (
    tick_s ##0 ref_delay > 17'h00002 |-> ##5 quiet_s)
    else $error("reference not restarted");
  chk_ready_fill: assert property (
    $fell(in_ready) |-> $past(in_valid)) else $error("refused unfilled");
endmodule : tff_formatter_properties
bind tff_formatter tff_formatter_properties chk (
  .mclk(mclk), .reset_n(reset_n), .clk4_pin(clk4_pin),
  .tick60_pin(tick60_pin), .sec_pin(sec_pin), .ref_delay(ref_delay),
  .in_valid(in_valid), .in_ready(in_ready), .video_out_q(video_out_q),
  .ref60_q(ref60_q), .frame_num_q(frame_num_q)
);
`default_nettype wire

// ---- verification/tff_recorder_model.sv ----
// recorder record input: logs the diphase stream as half-cell pairs
`timescale 1ns/10ps
`default_nettype none
module tff_recorder_model (
  input wire logic mclk,
  input wire logic clk4_pin,
  input wire logic video_out_q
);
  logic [1:0] cells[$];
  logic c4_q;
  logic first_q;
  int cnt_q;
  // sample each half mid-way, log the cell early in the next one
  always @(posedge mclk) begin
    c4_q <= clk4_pin;
    cnt_q <= (clk4_pin && !c4_q) ? 0 : cnt_q + 1;
    if (cnt_q == 5) first_q <= video_out_q;
    if (cnt_q == 1) cells.push_back({first_q, video_out_q});
  end
endmodule : tff_recorder_model
`default_nettype wire

// ---- verification/tff_formatter_test.sv ----
// self-checking bench for the tape frame formatter
`timescale 1ns/10ps
`default_nettype none
module tff_formatter_test;
  logic mclk = 1'b0;
  logic clk4 = 1'b0;
  logic reset_n = 1'b0;
  logic tick60 = 1'b0;
  logic sec = 1'b0;
  logic [16:0] refd = 17'h1ffff;
  logic in_valid = 1'b0;
  logic in_ready, video, tc, ref60;
  logic [5:0] fnum;
  int k_cnt = 0;
  int cyc = 0;
  int t0 = 0;
  int error_cnt = 0;
  int checked = 0;
  // main clock and a cell clock off its edges
  always #4 mclk = ~mclk;
  initial begin
    #2;
    forever #32 clk4 = ~clk4;
  end
  // cycle count and bits taken by the buffer
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (in_valid && in_ready) k_cnt <= k_cnt + 1;
  end
  function automatic logic pat(input int k);
    return k[0] ^ k[2] ^ k[5];
  endfunction : pat
  tff_formatter uut (
    .mclk(mclk), .reset_n(reset_n), .ce(1'b1), .clk4_pin(clk4),
    .tick60_pin(tick60), .sec_pin(sec), .long_frame_pin(1'b0),
    .unit_pin(4'h5), .tod_digits(36'h912345678), .ref_delay(refd),
    .in_valid(in_valid), .in_data(pat(k_cnt)), .in_ready(in_ready),
    .video_out_q(video), .tc_out_q(tc), .ref60_q(ref60),
    .frame_num_q(fnum)
  );
  tff_recorder_model rec (.mclk(mclk), .clk4_pin(clk4), .video_out_q(video));
  //////////////////////////////////////////////////////////////////
  task cmp(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : cmp
  task close_out;
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : close_out
  // frame tick just after a cell edge, log restarted
  task pulse(input logic s);
    @(posedge clk4);
    @(posedge mclk);
    #1 sec = s;
    tick60 = 1'b1;
    t0 = cyc;
    rec.cells.delete();
    repeat (4) @(posedge mclk);
    #1 tick60 = 1'b0;
    sec = 1'b0;
  endtask : pulse
  task t_fill;
    @(posedge mclk);
    #1 in_valid = 1'b1;
    repeat (8) @(posedge mclk);
    #1 cmp(k_cnt[15:0], 16'h0002);
    cmp({15'h0, in_ready}, 16'h0000);
  endtask : t_fill
  task t_feed;
    do begin
      @(posedge mclk);
      #1;
    end while (k_cnt < 300);
    in_valid = 1'b0;
  endtask : t_feed
  task t_ref;
    while (ref60 !== 1'b1 && cyc < t0 + 300) @(posedge mclk);
    cmp({15'h0, cyc - t0 >= 76 && cyc - t0 <= 104}, 16'h0001);
    t0 = cyc;
    while (ref60 === 1'b1 && cyc < t0 + 9000) @(posedge mclk);
    cmp({15'h0, cyc - t0 >= 8000 && cyc - t0 <= 8016}, 16'h0001);
  endtask : t_ref
  task t_tc;
    int offs[4];
    logic lvl[4];
    int base;
    offs = '{2080, 6250, 10416, 14586};
    lvl = '{1'b1, 1'b0, 1'b0, 1'b1};
    base = t0;
    for (int j = 0; j < 4; j++) begin
      while (cyc < base + offs[j]) @(posedge mclk);
      #1 cmp({15'h0, tc}, {15'h0, lvl[j]});
    end
  endtask : t_tc
  task t_frame(input int base);
    int i;
    int d;
    logic b;
    logic [1:0] g;
    logic [1:0] e;
    logic [5:0] fn;
    while (cyc < base + 16700) @(posedge mclk);
    fn = 6'h01;
    d = 0;
    i = 0;
    while (i < 8 && rec.cells[i] !== 2'b11) i++;
    cmp({15'h0, i <= 2}, 16'h0001);
    for (int p = 0; p < 2060; p++) begin
      b = 1'b1;
      if (p == 9) b = 1'b0;
      else if (p >= 10 && p < 16) b = fn[15 - p];
      else if (p == 16) b = ^fn;
      else if (p >= 28 && p % 2048 == 0) b = 1'b0;
      else if (p >= 28 && p % 2048 < 2041) begin
        b = (d < 300) ? pat(d) : 1'b0;
        d++;
      end
      e = (p < 8) ? ((p % 4 < 2) ? 2'b11 : 2'b00) : {b, ~b};
      g = rec.cells[i + p];
      if (p < 8) cmp({14'h0, g}, {14'h0, e});
      else if (p < 28) cmp({14'h0, g}, {14'h0, e});
      else cmp({14'h0, g}, {14'h0, e});
    end
  endtask : t_frame
  task t_wrap;
    for (int n = 2; n < 62; n++) begin
      pulse(1'b0);
      repeat (20) @(posedge mclk);
      cmp({10'h0, fnum}, 16'(n % 60));
    end
    pulse(1'b1);
    repeat (20) @(posedge mclk);
    cmp({10'h0, fnum}, 16'h0000);
  endtask : t_wrap
  // a tick during the reference pulse cuts it and rearms the delay
  task t_retick;
    while (ref60 !== 1'b1 && cyc < t0 + 300) @(posedge mclk);
    cmp({15'h0, ref60}, 16'h0001);
    pulse(1'b1);
    cmp({15'h0, ref60}, 16'h0000);
  endtask : t_retick
  //////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    int base;
    repeat (5) @(posedge mclk);
    #1 reset_n = 1'b1;
    t_fill();
    pulse(1'b1);
    repeat (150) @(posedge mclk);
    #1 refd = 17'h0000a;
    pulse(1'b0);
    base = t0;
    fork
      t_feed();
      t_ref();
      t_tc();
    join
    t_frame(base);
    t_wrap();
    t_retick();
    close_out();
  end
  // watchdog
  initial begin
    #400000;
    error_cnt++;
    close_out();
  end
endmodule : tff_formatter_test
`default_nettype wire
